// >>> gen_seq_defines.svh
// constant offsets, fields, reset values and timing for the generator timers
`ifndef GEN_SEQ_DEFINES_SVH
`define GEN_SEQ_DEFINES_SVH

// register offsets
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_IRQ_STAT 8'h08
`define OFS_IRQ_MASK 8'h0c
`define OFS_SHED_WAIT 8'h10
`define OFS_START_WAIT 8'h14
`define OFS_TEST_WAIT 8'h18

// control fields and reset values
`define CTRL_ALARM_EN 0
`define CTRL_UG_MODE 1
`define CTRL_RST 2'h2

// live status fields
`define ST_LOAD_SHED 0
`define ST_GEN_START 1
`define ST_GEN_STOP 2
`define ST_GEN_ALARM 3
`define ST_TEST_ALARM 4
`define ST_COOL_RUN 5

// event bits of the sticky status and mask
`define EV_SHED 0
`define EV_STOP 1
`define EV_GEN_ALARM 2
`define EV_TEST_ALARM 3
`define EV_W 4

// timing in seconds
`define SHED_S_RST 16'h0000
`define START_S_RST 16'h0003
`define COOL_S 16'h003c
`define FAIL_S 16'h012c
`define TEST_S_RST 16'h0258

// one-second tick from the 200 MHz clock
`define CLK_HZ 200000000
`define TICK_S 1

`endif

// >>> gen_seq_pkg.sv
// types shared by the generator timer block
package gen_seq_pkg;
  typedef logic [15:0] secCount_type;
  typedef logic [7:0] regAddr_type;
  typedef logic [31:0] regData_type;
  typedef logic [6:0] pinVec_type;
endpackage

// >>> gen_seq_timers.sv
// generator sequencing timers: load shed, cool-down, fail watchdog, test limit
//
// Behaviour
// - load-shed delay resets to zero seconds
// - load-shed output follows shed need, both modes
// - cool-down runs before generator stop asserts
// - cool-down also runs after restart in generator mode
// - cool-down waits for start delay or feed
// - fail watchdog counts 300 s after start
// - enabled alarm raised when watchdog expires
// - alarm cleared when either feed in range
// - alarm enable off after reset, blocks alarm
// - watchdog idle without auxiliary power
// - on-load test overrun raises alarm
// - cool-down lasts sixty seconds fixed
// - start delay before start signal, 3 s
//
// Chosen here: the register addresses and strobed register access.
`include "gen_seq_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module gen_seq_timers
#(
  parameter int unsigned TICK_CYCLES = `CLK_HZ * `TICK_S
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire gen_seq_pkg::regAddr_type regAddr,
  input wire gen_seq_pkg::regData_type wrData,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  output gen_seq_pkg::regData_type rdData,
  input wire logic shedNeeded,
  input wire logic preferredClosed,
  input wire logic secondFeedOk,
  input wire logic preferredOk,
  input wire logic genStartRequest,
  input wire logic auxPowerOk,
  input wire logic loadedTestActive,
  output logic loadShed,
  output logic genStart,
  output logic genStop,
  output logic genAlarm,
  output logic testAlarm,
  output logic irq
);
  import gen_seq_pkg::*;
  localparam logic [27:0] TICK_LAST = 28'(TICK_CYCLES - 1);
  // refuse tick periods the counter cannot hold
  if (TICK_CYCLES < 1 || TICK_CYCLES > 268435456)
  begin : badTick
    $error("TICK_CYCLES out of range");
  end
  // timer step: idle at zero unless running, counts seconds up to limit
  function automatic secCount_type stepCount(input logic run,
    input logic tick, input secCount_type cnt, input secCount_type lim);
    stepCount = cnt;
    if (!run)
      stepCount = '0;
    else if (tick && cnt < lim)
      stepCount = cnt + 16'h0001;
  endfunction
  pinVec_type pinsMeta_r;
  pinVec_type pinsSync_r;
  logic [27:0] tickCnt_r;
  logic tick_r;
  logic [1:0] ctrl_r;
  logic [`EV_W-1:0] irqStat_r;
  logic [`EV_W-1:0] irqMask_r;
  secCount_type shedWait_r;
  secCount_type startWait_r;
  secCount_type testWait_r;
  secCount_type shedCnt_r;
  secCount_type startCnt_r;
  secCount_type coolCnt_r;
  secCount_type failCnt_r;
  secCount_type testCnt_r;
  logic coolArm_r;
  logic loadShed_r;
  logic genStart_r;
  logic genStop_r;
  logic genAlarm_r;
  logic testAlarm_r;
  logic irq_r;
  regData_type rdData_r;
  logic [`EV_W-1:0] events;
  logic shedReq, prefClosed, secondOk, prefOk, startReq, auxOk, testOn;
  logic alarmEn, ugMode;
  logic shedRun, startRun, coolRun, failRun, testRun;
  logic shedDone, startDone, coolDone, failDone, testDone;

  // two-stage synchroniser for all pin inputs
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pinsMeta_r <= '0;
      pinsSync_r <= '0;
    end
    else
    begin
      pinsMeta_r <= {loadedTestActive, auxPowerOk, genStartRequest,
        preferredOk, secondFeedOk, preferredClosed, shedNeeded};
      pinsSync_r <= pinsMeta_r;
    end
  end
  assign {testOn, auxOk, startReq, prefOk, secondOk, prefClosed,
    shedReq} = pinsSync_r;
  assign alarmEn = ctrl_r[`CTRL_ALARM_EN];
  assign ugMode = ctrl_r[`CTRL_UG_MODE];
  // one-second tick, restarted by reset
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tickCnt_r <= '0;
      tick_r <= 1'b0;
    end
    else
    begin
      tick_r <= (tickCnt_r == TICK_LAST);
      tickCnt_r <= (tickCnt_r == TICK_LAST) ? 28'h0000000 :
        tickCnt_r + 28'h0000001;
    end
  end

  // run conditions; dropping one reloads its timer
  assign shedRun = shedReq;
  assign startRun = ugMode && startReq && !genStart_r;
  assign coolRun = ugMode && prefClosed && !startReq && coolArm_r &&
    !genStop_r;
  assign failRun = genStart_r && auxOk && !secondOk;
  assign testRun = testOn && !testAlarm_r;
  assign shedDone = shedRun && shedCnt_r >= shedWait_r;
  assign startDone = startRun && startCnt_r >= startWait_r;
  assign coolDone = coolRun && coolCnt_r >= `COOL_S;
  assign failDone = failRun && failCnt_r >= `FAIL_S;
  assign testDone = testRun && testCnt_r >= testWait_r;
  // second counters, all zero after reset; cool-down counts straight away in generator mode
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      shedCnt_r <= '0;
      startCnt_r <= '0;
      coolCnt_r <= '0;
      failCnt_r <= '0;
      testCnt_r <= '0;
    end
    else
    begin
      shedCnt_r <= stepCount(shedRun, tick_r, shedCnt_r, shedWait_r);
      startCnt_r <= stepCount(startRun, tick_r, startCnt_r, startWait_r);
      coolCnt_r <= stepCount(coolRun, tick_r, coolCnt_r, `COOL_S);
      failCnt_r <= stepCount(failRun, tick_r, failCnt_r, `FAIL_S);
      testCnt_r <= stepCount(testRun, tick_r, testCnt_r, testWait_r);
    end
  end

  // load-shed output
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      loadShed_r <= 1'b0;
    else
      loadShed_r <= shedDone;
  end

  // generator start and stop; arm set at reset covers a restart
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      genStart_r <= 1'b0;
      genStop_r <= 1'b0;
      coolArm_r <= 1'b1;
    end
    else
    begin
      if (startDone)
      begin
        genStart_r <= 1'b1;
        genStop_r <= 1'b0;
      end
      else if (coolDone)
      begin
        genStart_r <= 1'b0;
        genStop_r <= 1'b1;
      end
      if (coolDone)
        coolArm_r <= 1'b0;
      else if (startDone || (ugMode && secondOk))
        coolArm_r <= 1'b1;
    end
  end

  // generator fail alarm; in-range feed clears it first
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      genAlarm_r <= 1'b0;
    else if (secondOk || prefOk)
      genAlarm_r <= 1'b0;
    else if (failDone && alarmEn)
      genAlarm_r <= 1'b1;
  end

  // on-load test overrun alarm, dropped when the test ends
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      testAlarm_r <= 1'b0;
    else if (!testOn)
      testAlarm_r <= 1'b0;
    else if (testDone)
      testAlarm_r <= 1'b1;
  end

  assign events[`EV_SHED] = shedDone && !loadShed_r;
  assign events[`EV_STOP] = coolDone;
  assign events[`EV_GEN_ALARM] = failDone && alarmEn && !genAlarm_r &&
    !secondOk && !prefOk;
  assign events[`EV_TEST_ALARM] = testDone;

  // register writes; a new event wins over a write-one clear
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl_r <= `CTRL_RST;
      irqMask_r <= '0;
      irqStat_r <= '0;
      shedWait_r <= `SHED_S_RST;
      startWait_r <= `START_S_RST;
      testWait_r <= `TEST_S_RST;
    end
    else
    begin
      if (wrStrobe && regAddr == `OFS_IRQ_STAT)
        irqStat_r <= (irqStat_r & ~wrData[`EV_W-1:0]) | events;
      else
        irqStat_r <= irqStat_r | events;
      if (wrStrobe)
      begin
        case (regAddr)
          `OFS_CTRL: ctrl_r <= wrData[1:0];
          `OFS_IRQ_MASK: irqMask_r <= wrData[`EV_W-1:0];
          `OFS_SHED_WAIT: shedWait_r <= wrData[15:0];
          `OFS_START_WAIT: startWait_r <= wrData[15:0];
          `OFS_TEST_WAIT: testWait_r <= wrData[15:0];
          default: ;
        endcase
      end
    end
  end

  // read data one cycle after the strobe, zero elsewhere
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      rdData_r <= '0;
    else if (!rdStrobe)
      rdData_r <= '0;
    else
    begin
      case (regAddr)
        `OFS_CTRL: rdData_r <= {30'h00000000, ctrl_r};
        `OFS_STATUS: rdData_r <= {26'h0000000, coolRun, testAlarm_r,
          genAlarm_r, genStop_r, genStart_r, loadShed_r};
        `OFS_IRQ_STAT: rdData_r <= {28'h0000000, irqStat_r};
        `OFS_IRQ_MASK: rdData_r <= {28'h0000000, irqMask_r};
        `OFS_SHED_WAIT: rdData_r <= {16'h0000, shedWait_r};
        `OFS_START_WAIT: rdData_r <= {16'h0000, startWait_r};
        `OFS_TEST_WAIT: rdData_r <= {16'h0000, testWait_r};
        default: rdData_r <= '0;
      endcase
    end
  end

  // level interrupt from unmasked sticky bits
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      irq_r <= 1'b0;
    else
      irq_r <= |(irqStat_r & irqMask_r);
  end

  assign rdData = rdData_r;
  assign loadShed = loadShed_r;
  assign genStart = genStart_r;
  assign genStop = genStop_r;
  assign genAlarm = genAlarm_r;
  assign testAlarm = testAlarm_r;
  assign irq = irq_r;

  // checks on the timer behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence coolFull;
    coolRun && coolCnt_r == `COOL_S;
  endsequence

  sequence stopRaised;
    !genStart_r && genStop_r;
  endsequence
  shed_zero_a: assert property ((shedReq && shedWait_r == '0) |=> loadShed_r)
    else $error("load shed waited with zero delay");
  shed_drop_a: assert property (!shedReq |=> !loadShed_r)
    else $error("load shed held without need");
  stop_cool_a: assert property ($rose(genStop_r) |-> $past(coolCnt_r) == `COOL_S)
    else $error("generator stop before full cool-down");
  cool_stop_a: assert property (coolFull |=> stopRaised)
    else $error("cool-down end did not stop generator");
  cool_gate_a: assert property (
    (coolCnt_r == '0 && !coolArm_r) |=> coolCnt_r == '0)
    else $error("cool-down ran before start finished");
  fail_time_a: assert property ($rose(genAlarm_r) |-> $past(failCnt_r) == `FAIL_S)
    else $error("alarm before fail time");
  alarm_enable_a: assert property ($rose(genAlarm_r) |-> $past(alarmEn))
    else $error("alarm raised while disabled");
  alarm_clear_a: assert property ((secondOk || prefOk) |=> !genAlarm_r)
    else $error("alarm kept with feed in range");
  fail_idle_a: assert property (!auxOk |=> failCnt_r == '0)
    else $error("fail timer ran without aux power");
  test_time_a: assert property ($rose(testAlarm_r) |-> $past(testCnt_r) == $past(testWait_r))
    else $error("test alarm at wrong time");
  start_delay_a: assert property ($rose(genStart_r) |-> $past(startCnt_r) == $past(startWait_r))
    else $error("start asserted at wrong time");
  tick_period_a: assert property (tick_r |-> tickCnt_r == 28'h0000000)
    else $error("tick out of step with divider");
  cool_reload_a: assert property (!coolRun |=> coolCnt_r == '0)
    else $error("cool-down kept count after withdrawal");

endmodule

`default_nettype wire

// >>> gen_model.sv
// behavioural standby generator that reports ready after starting
`timescale 1ns/10ps
`default_nettype none
module gen_model
#(
  parameter int READY_CYCLES = 20
)
(
  input wire logic clk,
  input wire logic genStart,
  input wire logic slow,
  output logic secondFeedOk
);
  int cnt = 0;
  initial secondFeedOk = 1'h0;
  // run-up counts while asked to start; a slow set never comes up
  always @(posedge clk)
  begin
    if (!genStart || slow)
      cnt <= 0;
    else if (cnt < READY_CYCLES)
      cnt <= cnt + 1;
    secondFeedOk <= genStart && !slow && cnt == READY_CYCLES;
  end
endmodule
`default_nettype wire

// >>> gen_seq_timers_test.sv
// self-checking bench for the generator sequencing timers
`include "gen_seq_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module gen_seq_timers_test;
  import gen_seq_pkg::*;
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  regAddr_type regAddr = 8'h00;
  regData_type wrData = 32'h0;
  regData_type rdData;
  logic wrStrobe = 1'h0, rdStrobe = 1'h0, shedNeeded = 1'h0;
  logic preferredClosed = 1'h1, preferredOk = 1'h0, genStartRequest = 1'h0;
  logic auxPowerOk = 1'h1, loadedTestActive = 1'h0, slow = 1'h1;
  logic secondFeedOk, loadShed, genStart, genStop, genAlarm, testAlarm, irq;
  logic p1 = 1'h0;
  regData_type expQ[$];
  int failures = 0, checks_done = 0, cyc = 0, w;
  wire logic [5:0] outVec;
  assign outVec = {irq, testAlarm, genAlarm, genStop, genStart, loadShed};

  // clock at 200 MHz
  always #2.5 clk = ~clk;

  gen_seq_timers #(.TICK_CYCLES(10)) gen_seq_timers_i (.clk(clk),
    .sys_rst(sys_rst), .regAddr(regAddr), .wrData(wrData),
    .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
    .shedNeeded(shedNeeded), .preferredClosed(preferredClosed),
    .secondFeedOk(secondFeedOk), .preferredOk(preferredOk),
    .genStartRequest(genStartRequest), .auxPowerOk(auxPowerOk),
    .loadedTestActive(loadedTestActive), .loadShed(loadShed),
    .genStart(genStart), .genStop(genStop), .genAlarm(genAlarm),
    .testAlarm(testAlarm), .irq(irq));

  gen_model gen_model_i (.clk(clk), .genStart(genStart), .slow(slow),
    .secondFeedOk(secondFeedOk));

  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] s);
    checks_done++;
    if (s !== e)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic summarize();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic wr(input regAddr_type a, input regData_type d);
    @(posedge clk);
    regAddr <= a;
    wrData <= d;
    wrStrobe <= 1'h1;
    @(posedge clk);
    wrStrobe <= 1'h0;
  endtask

  // read request; the expected word waits in the queue for the monitor
  task automatic rd(input regAddr_type a, input regData_type e);
    @(posedge clk);
    regAddr <= a;
    rdStrobe <= 1'h1;
    expQ.push_back(e);
    @(posedge clk);
    rdStrobe <= 1'h0;
  endtask

  // waits for an output level and checks the cycle count lands in range
  task automatic waitOut(input int b, input logic v, input int lo,
    input int hi, input string nm);
    int n;
    n = 0;
    @(negedge clk);
    while (outVec[b] !== v && n <= hi)
    begin
      n++;
      @(negedge clk);
    end
    chk(nm, 32'h1, {31'h0, n >= lo && n <= hi});
  endtask

  // read data stand in the cycle after the strobe: compare the oldest note
  always @(posedge clk)
  begin
    p1 <= rdStrobe;
    if (p1)
      chk("rdData", expQ.pop_front(), rdData);
  end

  // cuts a hang short
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 9000)
    begin
      failures++;
      summarize();
    end
  end

  initial
  begin
    w = $urandom(32'h2255373c);
    w = 2 + $urandom % 4;
    repeat (2) @(posedge clk);
    sys_rst <= 1'h0;
    // cool-down armed out of reset in generator mode
    waitOut(2, 1'h1, 590, 620, "genStop");
    rd(`OFS_CTRL, 32'h2);
    rd(`OFS_SHED_WAIT, 32'h0);
    rd(`OFS_START_WAIT, 32'h3);
    rd(`OFS_TEST_WAIT, 32'h258);
    rd(8'h40, 32'h0);
    $display("reset and restart cool-down done");
    // load shed with zero wait, its interrupt raised and cleared
    wr(`OFS_IRQ_MASK, 32'h1);
    shedNeeded <= 1'h1;
    waitOut(0, 1'h1, 1, 5, "loadShed");
    waitOut(5, 1'h1, 0, 4, "irq set");
    rd(`OFS_IRQ_STAT, 32'h3);
    wr(`OFS_IRQ_STAT, 32'h3);
    waitOut(5, 1'h0, 0, 4, "irq clear");
    rd(`OFS_IRQ_STAT, 32'h0);
    shedNeeded <= 1'h0;
    waitOut(0, 1'h0, 1, 5, "loadShed off");
    $display("load shed done");
    // generator start, watchdog expiry with a generator that never comes up
    wr(`OFS_CTRL, 32'h3);
    preferredClosed <= 1'h0;
    genStartRequest <= 1'h1;
    waitOut(1, 1'h1, 28, 46, "genStart");
    // watchdog held idle while auxiliary power is away, full delay after
    @(posedge clk);
    auxPowerOk <= 1'h0;
    repeat (200) @(posedge clk);
    auxPowerOk <= 1'h1;
    waitOut(3, 1'h1, 2995, 3016, "genAlarm");
    rd(`OFS_STATUS, 32'ha);
    rd(`OFS_IRQ_STAT, 32'h4);
    @(posedge clk);
    preferredOk <= 1'h1;
    waitOut(3, 1'h0, 1, 5, "genAlarm clear");
    @(posedge clk);
    slow <= 1'h0;
    $display("generator watchdog done");
    // on-load test limit, withdrawn once before expiry
    wr(`OFS_TEST_WAIT, regData_type'(w));
    rd(`OFS_TEST_WAIT, regData_type'(w));
    loadedTestActive <= 1'h1;
    repeat (w * 10 - 10) @(posedge clk);
    loadedTestActive <= 1'h0;
    repeat (4) @(posedge clk);
    loadedTestActive <= 1'h1;
    waitOut(4, 1'h1, w * 10 - 7, w * 10 + 16, "testAlarm");
    @(posedge clk);
    loadedTestActive <= 1'h0;
    waitOut(4, 1'h0, 1, 5, "testAlarm clear");
    $display("on-load test limit done");
    summarize();
  end
endmodule
`default_nettype wire
